// ==== fault_pgood_pkg.sv ====
// Shared constants and carrier types for the fault-zone and power-good mapping block
package fault_pgood_pkg;

	// ---------------------------------------------------------------
	// Channel and zone layout
	// ---------------------------------------------------------------
	localparam int unsigned N_CHAN        = 8;
	localparam int unsigned N_ZONE_CHAN   = 4;
	localparam int unsigned ZONE0_LO      = 0;
	localparam int unsigned ZONE1_LO      = 4;
	localparam logic [7:0]  ODD_CHAN_MASK = 8'hAA;

	// ---------------------------------------------------------------
	// Command codes of the register port
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_ZONE0_PIN_A_PROP = 8'hD2;
	localparam logic [7:0] CMD_ZONE0_PIN_B_PROP = 8'hD3;
	localparam logic [7:0] CMD_ZONE1_PIN_A_PROP = 8'hD4;
	localparam logic [7:0] CMD_ZONE1_PIN_B_PROP = 8'hD5;
	localparam logic [7:0] CMD_PGOOD_SRC_MASK   = 8'hD6;
	localparam logic [7:0] CMD_PIN_STATUS       = 8'hD7;

	// ---------------------------------------------------------------
	// Field positions and widths
	// ---------------------------------------------------------------
	localparam int unsigned PROP_EN_BIT     = 0;
	localparam int unsigned PGOOD_WDOG_BIT  = 8;
	localparam int unsigned PGOOD_STORED_W  = 9;
	localparam int unsigned DATA_W          = 16;
	localparam int unsigned STAT_PGOOD_BIT  = 8;
	localparam int unsigned STAT_LEVEL_LO   = 4;
	localparam int unsigned STAT_DRIVE_LO   = 0;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic       PROP_EN_RESET    = 1'b0;
	localparam logic [8:0] PGOOD_MASK_RESET = 9'h000;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  cmd;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        valid;
		logic        nack;
		logic [15:0] rdata;
	} reg_rsp_t;

	// Pin order: [0] zone0 pin a, [1] zone0 pin b, [2] zone1 pin a, [3] zone1 pin b
	typedef struct packed {
		logic [3:0] o;
		logic [3:0] oe;
	} fault_pins_t;

endpackage

// ==== fault_zone_combine.sv ====
// Per-zone combining of faulted-off channels onto the zone's two fault pins
`timescale 1ns/10ps

module fault_zone_combine #(
	parameter int unsigned N_ZONE_CHAN = 4
) (
	input  wire logic [N_ZONE_CHAN-1:0] i_faulted_off,
	input  wire logic                   i_pin_a_prop_en,
	input  wire logic                   i_pin_b_prop_en,
	output wire logic                   o_pull_pin_a,
	output wire logic                   o_pull_pin_b
);

	generate
		if (N_ZONE_CHAN < 1) begin : g_bad
			$error("fault_zone_combine needs at least one channel");
		end
	endgenerate

	wire logic any_faulted_off;

	// Only channels that faulted off count
	assign any_faulted_off = |i_faulted_off;

	assign o_pull_pin_a = any_faulted_off & i_pin_a_prop_en;
	assign o_pull_pin_b = any_faulted_off & i_pin_b_prop_en;

endmodule

// ==== fault_pgood_map.sv ====
// Fault-zone pin propagation and power-good mapping with its register set
//
// Notes on behaviour
// - Zone-0 pin b enable set: pull zone-0 pin b low on zone-0 fault.
// - Zone-0 pin b enable clear: faults leave zone-0 pin b alone.
// - Zone-1 pin a enable set pulls it low on fault; clear leaves it.
// - Zone-1 pin b enable set pulls it low on fault; clear leaves it.
// - Propagation registers ignore writes to bits 15..1 and read them as zero.
// - Zone-0 registers cover channels 0..3, zone-1 registers cover 4..7.
// - Each enabled channel's power-good status, bar odd channels in high-resolution mode, is a term of the power-good AND.
// - A disabled channel has no influence on power good.
// - Mask bit 8 set: watchdog not-expired status joins the AND.
// - Mask bit 8 clear: watchdog state does not affect power good.
// - Odd channels in high-resolution mode never join the AND.
// - Power-good mask bits 15..9 are read-only and read as zero.
// - Only faulted-off channels propagate, each to its own zone's pins.
// - Zone-0 pin a enable set pulls it low on fault; clear leaves it.
`timescale 1ns/10ps

module fault_pgood_map #(
	parameter int unsigned N_CHAN      = fault_pgood_pkg::N_CHAN,
	parameter int unsigned N_ZONE_CHAN = fault_pgood_pkg::N_ZONE_CHAN
) (
	input  wire logic                        i_sys_clk,
	input  wire logic                        i_arst_n,
	input  wire logic                        i_clk_en,
	input  wire fault_pgood_pkg::reg_req_t   i_reg_req,
	output      fault_pgood_pkg::reg_rsp_t   o_reg_rsp,
	input  wire logic [N_CHAN-1:0]           i_chan_faulted_off,
	input  wire logic [N_CHAN-1:0]           i_chan_pgood,
	input  wire logic [N_CHAN-1:0]           i_chan_high_res,
	input  wire logic                        i_wdog_expired,
	input  wire logic [3:0]                  i_fault_pin_level,
	output      fault_pgood_pkg::fault_pins_t o_fault_pins,
	output      logic                        o_pgood
);

	// ---------------------------------------------------------------
	// Parameter checks
	// ---------------------------------------------------------------
	generate
		if (N_CHAN != 2 * N_ZONE_CHAN || N_CHAN != fault_pgood_pkg::N_CHAN) begin : g_bad
			$error("fault_pgood_map serves exactly two zones of four channels");
		end
	endgenerate

	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic                                         z0_pin_a_prop_en_r;
	logic                                         z0_pin_b_prop_en_r;
	logic                                         z1_pin_a_prop_en_r;
	logic                                         z1_pin_b_prop_en_r;
	logic [fault_pgood_pkg::PGOOD_STORED_W-1:0]   pgood_mask_r;
	logic [fault_pgood_pkg::PGOOD_STORED_W-1:0]   pgood_mask_nxt;
	logic [3:0]                                   pin_level_r;

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	wire logic hit_z0_a;
	wire logic hit_z0_b;
	wire logic hit_z1_a;
	wire logic hit_z1_b;
	wire logic hit_mask;
	wire logic hit_stat;
	wire logic hit_any;
	wire logic wr_en;
	wire logic new_prop_bit;

	assign hit_z0_a = i_reg_req.cmd == fault_pgood_pkg::CMD_ZONE0_PIN_A_PROP;
	assign hit_z0_b = i_reg_req.cmd == fault_pgood_pkg::CMD_ZONE0_PIN_B_PROP;
	assign hit_z1_a = i_reg_req.cmd == fault_pgood_pkg::CMD_ZONE1_PIN_A_PROP;
	assign hit_z1_b = i_reg_req.cmd == fault_pgood_pkg::CMD_ZONE1_PIN_B_PROP;
	assign hit_mask = i_reg_req.cmd == fault_pgood_pkg::CMD_PGOOD_SRC_MASK;
	assign hit_stat = i_reg_req.cmd == fault_pgood_pkg::CMD_PIN_STATUS;
	assign hit_any  = hit_z0_a | hit_z0_b | hit_z1_a | hit_z1_b | hit_mask | hit_stat;
	assign wr_en    = i_clk_en & i_reg_req.wr;

	// Only bit 0 is kept; upper bits of the 16-bit word are dropped
	assign new_prop_bit = i_reg_req.wdata[fault_pgood_pkg::PROP_EN_BIT];

	// Bits 15..9 never stored
	assign pgood_mask_nxt = i_reg_req.wdata[fault_pgood_pkg::PGOOD_STORED_W-1:0];

	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			z0_pin_a_prop_en_r <= fault_pgood_pkg::PROP_EN_RESET;
			z0_pin_b_prop_en_r <= fault_pgood_pkg::PROP_EN_RESET;
			z1_pin_a_prop_en_r <= fault_pgood_pkg::PROP_EN_RESET;
			z1_pin_b_prop_en_r <= fault_pgood_pkg::PROP_EN_RESET;
		end else if (wr_en) begin
			if (hit_z0_a) begin
				z0_pin_a_prop_en_r <= new_prop_bit;
			end
			if (hit_z0_b) begin
				z0_pin_b_prop_en_r <= new_prop_bit;
			end
			if (hit_z1_a) begin
				z1_pin_a_prop_en_r <= new_prop_bit;
			end
			if (hit_z1_b) begin
				z1_pin_b_prop_en_r <= new_prop_bit;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pgood_mask_r <= fault_pgood_pkg::PGOOD_MASK_RESET;
		end else if (wr_en && hit_mask) begin
			pgood_mask_r <= pgood_mask_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Fault-zone combining
	// ---------------------------------------------------------------
	wire logic [3:0] pull_low;

	// Zone 0 sees channels 0..3 only
	fault_zone_combine #(
		.N_ZONE_CHAN (N_ZONE_CHAN)
	) u_zone0 (
		.i_faulted_off   (i_chan_faulted_off[fault_pgood_pkg::ZONE0_LO +: N_ZONE_CHAN]),
		.i_pin_a_prop_en (z0_pin_a_prop_en_r),
		.i_pin_b_prop_en (z0_pin_b_prop_en_r),
		.o_pull_pin_a    (pull_low[0]),
		.o_pull_pin_b    (pull_low[1])
	);

	// Zone 1 sees channels 4..7 only
	fault_zone_combine #(
		.N_ZONE_CHAN (N_ZONE_CHAN)
	) u_zone1 (
		.i_faulted_off   (i_chan_faulted_off[fault_pgood_pkg::ZONE1_LO +: N_ZONE_CHAN]),
		.i_pin_a_prop_en (z1_pin_a_prop_en_r),
		.i_pin_b_prop_en (z1_pin_b_prop_en_r),
		.o_pull_pin_a    (pull_low[2]),
		.o_pull_pin_b    (pull_low[3])
	);

	// Enable clear means the pin is released, never pulled
	// ---------------------------------------------------------------
	// Open-drain fault pin drivers
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_fault_pins.o  <= 4'h0;
			o_fault_pins.oe <= 4'h0;
		end else if (i_clk_en) begin
			o_fault_pins.o  <= 4'h0;
			o_fault_pins.oe <= pull_low;
		end
	end

	// ---------------------------------------------------------------
	// Power-good mapping
	// ---------------------------------------------------------------
	wire logic [N_CHAN-1:0] chan_term_en;
	wire logic [N_CHAN-1:0] chan_term_ok;
	wire logic              wdog_term_ok;
	wire logic              pgood_nxt;

	// High-res odd channels drop out whatever their enable
	assign chan_term_en = pgood_mask_r[N_CHAN-1:0]
		& ~(i_chan_high_res & fault_pgood_pkg::ODD_CHAN_MASK);

	// Disabled channels are forced true in the AND
	assign chan_term_ok = i_chan_pgood | ~chan_term_en;

	assign wdog_term_ok = ~pgood_mask_r[fault_pgood_pkg::PGOOD_WDOG_BIT]
		| ~i_wdog_expired;

	assign pgood_nxt = (&chan_term_ok) & wdog_term_ok;

	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_pgood <= 1'b0;
		end else if (i_clk_en) begin
			o_pgood <= pgood_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Pin level sampling
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pin_level_r <= 4'hF;
		end else if (i_clk_en) begin
			pin_level_r <= i_fault_pin_level;
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	wire logic [15:0] rd_prop_z0_a;
	wire logic [15:0] rd_prop_z0_b;
	wire logic [15:0] rd_prop_z1_a;
	wire logic [15:0] rd_prop_z1_b;
	wire logic [15:0] rd_mask;
	wire logic [15:0] rd_stat;
	wire logic [15:0] rd_mux;

	// Reserved bits return zero
	assign rd_prop_z0_a = {15'h0000, z0_pin_a_prop_en_r};
	assign rd_prop_z0_b = {15'h0000, z0_pin_b_prop_en_r};
	assign rd_prop_z1_a = {15'h0000, z1_pin_a_prop_en_r};
	assign rd_prop_z1_b = {15'h0000, z1_pin_b_prop_en_r};
	assign rd_mask      = {7'h00, pgood_mask_r};
	assign rd_stat      = {7'h00, o_pgood, pin_level_r, o_fault_pins.oe};

	assign rd_mux = hit_z0_a ? rd_prop_z0_a :
		hit_z0_b ? rd_prop_z0_b :
		hit_z1_a ? rd_prop_z1_a :
		hit_z1_b ? rd_prop_z1_b :
		hit_mask ? rd_mask :
		hit_stat ? rd_stat : 16'h0000;

	wire logic access;
	wire logic bad_write;

	assign access    = i_clk_en & (i_reg_req.wr | i_reg_req.rd);
	assign bad_write = i_reg_req.wr & (hit_stat | ~hit_any);

	always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_reg_rsp <= '0;
		end else if (i_clk_en) begin
			o_reg_rsp.valid <= access;
			o_reg_rsp.nack  <= access & (~hit_any | bad_write);
			o_reg_rsp.rdata <= (access && i_reg_req.rd) ? rd_mux : 16'h0000;
		end
	end

endmodule

// ==== fault_bus_peer.sv ====
// Wired-AND fault bus: pull-ups plus peer supervisors sharing the four pins
`timescale 1ns/10ps

module fault_bus_peer (
	input  wire logic [3:0] i_dev_oe,
	input  wire logic [3:0] i_peer_pull,
	output wire logic [3:0] o_wire_level
);
	// Released pins rise through the pull-up, any pulling party wins
	assign o_wire_level = ~(i_dev_oe | i_peer_pull);
endmodule

// ==== fault_pgood_map_monitor.sv ====
// Assertion checker for the fault-zone and power-good mapping block
`timescale 1ns/10ps

module fault_pgood_map_monitor #(
	parameter int unsigned N_CHAN = 8
) (
	input wire logic                         i_sys_clk,
	input wire logic                         i_arst_n,
	input wire logic                         i_clk_en,
	input wire fault_pgood_pkg::reg_req_t    i_reg_req,
	input wire fault_pgood_pkg::reg_rsp_t    o_reg_rsp,
	input wire logic [N_CHAN-1:0]            i_chan_faulted_off,
	input wire logic [N_CHAN-1:0]            i_chan_pgood,
	input wire logic [N_CHAN-1:0]            i_chan_high_res,
	input wire logic                         i_wdog_expired,
	input wire logic [3:0]                   i_fault_pin_level,
	input wire fault_pgood_pkg::fault_pins_t o_fault_pins,
	input wire logic                         o_pgood
);
	logic [1:0] run_r;
	logic [8:0] mask_r;
	logic [3:0] en_r;
	wire        go     = run_r[1] & i_clk_en;
	wire        wr_go  = go & i_reg_req.wr;
	wire        z0     = |i_chan_faulted_off[3:0];
	wire        z1     = |i_chan_faulted_off[7:4];
	wire [3:0]  oe_exp = en_r & {z1, z1, z0, z0};
	wire [7:0]  used   = mask_r[7:0] & ~(i_chan_high_res & fault_pgood_pkg::ODD_CHAN_MASK);
	wire        pg_exp = (&(i_chan_pgood | ~used)) & (~mask_r[8] | ~i_wdog_expired);
	wire        prop   = i_reg_req.cmd inside {[fault_pgood_pkg::CMD_ZONE0_PIN_A_PROP :
		fault_pgood_pkg::CMD_ZONE1_PIN_B_PROP]};

	// ---------------------------------------------------------------
	// Shadow of the reset sync and the configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			run_r <= 2'b00;
			mask_r <= 9'h000;
			en_r <= 4'h0;
		end else begin
			run_r <= {run_r[0], 1'b1};
			if (wr_go && prop)
				en_r[i_reg_req.cmd[1:0] + 2'd2] <= i_reg_req.wdata[0];
			if (wr_go && i_reg_req.cmd == fault_pgood_pkg::CMD_PGOOD_SRC_MASK)
				mask_r <= i_reg_req.wdata[8:0];
		end
	end

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);

	a_pin_data_low: assert property (o_fault_pins.o == 4'h0)
		else $error("fault pin data not low");
	a_rsp_one_later: assert property (go && (i_reg_req.wr || i_reg_req.rd) |=> o_reg_rsp.valid)
		else $error("access without response");
	a_no_stray_rsp: assert property (i_clk_en && !i_reg_req.wr && !i_reg_req.rd |=> !o_reg_rsp.valid)
		else $error("response without access");
	a_prop_rsvd_zero: assert property (
		go && i_reg_req.rd && prop |=> o_reg_rsp.rdata[15:1] == 15'h0)
		else $error("propagation reserved bits not zero");
	a_mask_rsvd_zero: assert property (go && i_reg_req.rd && i_reg_req.cmd ==
		fault_pgood_pkg::CMD_PGOOD_SRC_MASK |=> o_reg_rsp.rdata[15:9] == 7'h00)
		else $error("mask reserved bits not zero");
	a_zone0_quiet: assert property (go && !z0 |=> o_fault_pins.oe[1:0] == 2'b00)
		else $error("zone 0 pin pulled without fault");
	a_zone1_quiet: assert property (go && !z1 |=> o_fault_pins.oe[3:2] == 2'b00)
		else $error("zone 1 pin pulled without fault");
	a_oe_follows_en: assert property (
		go |=> o_fault_pins.oe == $past(oe_exp))
		else $error("fault pin drive wrong");
	a_pgood_and: assert property (
		go |=> o_pgood == $past(pg_exp))
		else $error("power good wrong");
	a_freeze_holds: assert property (run_r[1] && !i_clk_en |=> $stable(o_pgood)
		&& $stable(o_fault_pins) && $stable(o_reg_rsp))
		else $error("state moved while clock enable low");
endmodule

bind fault_pgood_map fault_pgood_map_monitor #(.N_CHAN(N_CHAN)) u_mon (
	.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en), .i_reg_req(i_reg_req),
	.o_reg_rsp(o_reg_rsp), .i_chan_faulted_off(i_chan_faulted_off), .i_chan_pgood(i_chan_pgood),
	.i_chan_high_res(i_chan_high_res), .i_wdog_expired(i_wdog_expired),
	.i_fault_pin_level(i_fault_pin_level), .o_fault_pins(o_fault_pins), .o_pgood(o_pgood));

// ==== fault_pgood_map_tb_top.sv ====
// Self-checking testbench for the fault-zone and power-good mapping block
`timescale 1ns/10ps

module fault_pgood_map_tb_top;
	logic                         sys_clk = 1'b0;
	logic                         arst_n = 1'b0;
	logic                         clk_en = 1'b1;
	fault_pgood_pkg::reg_req_t    req = '0;
	fault_pgood_pkg::reg_rsp_t    rsp;
	fault_pgood_pkg::fault_pins_t pins;
	logic [7:0]                   foff = 8'h00;
	logic [7:0]                   pg = 8'h00;
	logic [7:0]                   hr = 8'h00;
	logic                         wdx = 1'b0;
	logic [3:0]                   peer = 4'h0;
	logic [3:0]                   level;
	logic                         pgood;
	logic [16:0]                  exp_q[$];
	logic [31:0]                  seed = 32'h0000_9817;
	int                           err_count = 0;
	int                           cmp_count = 0;

	always #10 sys_clk = ~sys_clk;

	fault_pgood_map dut (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_clk_en(clk_en),
		.i_reg_req(req), .o_reg_rsp(rsp), .i_chan_faulted_off(foff), .i_chan_pgood(pg),
		.i_chan_high_res(hr), .i_wdog_expired(wdx), .i_fault_pin_level(level),
		.o_fault_pins(pins), .o_pgood(pgood));
	fault_bus_peer u_peer (.i_dev_oe(pins.oe), .i_peer_pull(peer), .o_wire_level(level));

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			err_count++;
		end
	endtask

	task reg_op(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [16:0] e);
		@(negedge sys_clk);
		req <= '{wr: w, rd: ~w, cmd: c, wdata: d};
		exp_q.push_back(e);
		@(negedge sys_clk);
		req <= '0;
	endtask

	task print_verdict();
		if (err_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(negedge sys_clk) begin
		if (rsp.valid === 1'b1) begin
			if (exp_q.size() == 0)
				chk("stray response", 17'h0_0001, 17'h0_0000);
			else
				chk("response", {rsp.nack, rsp.rdata}, exp_q.pop_front());
		end
	end

	initial begin
		logic [31:0] r;
		logic [31:0] s;
		logic [7:0]  used;
		logic [3:0]  de;
		logic        pg_exp;
		repeat (10) @(negedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(negedge sys_clk);
		// ---------------------------------------------------------------
		// Reset values, reserved bits, refused commands
		// ---------------------------------------------------------------
		for (int c = 0; c < 5; c++)
			reg_op(1'b0, fault_pgood_pkg::CMD_ZONE0_PIN_A_PROP + 8'(c), 16'h0000, 17'h0_0000);
		for (int c = 0; c < 4; c++) begin
			reg_op(1'b1, fault_pgood_pkg::CMD_ZONE0_PIN_A_PROP + 8'(c), 16'hFFFF, 17'h0_0000);
			reg_op(1'b0, fault_pgood_pkg::CMD_ZONE0_PIN_A_PROP + 8'(c), 16'h0000, 17'h0_0001);
		end
		reg_op(1'b1, fault_pgood_pkg::CMD_PGOOD_SRC_MASK, 16'hFFFF, 17'h0_0000);
		reg_op(1'b0, fault_pgood_pkg::CMD_PGOOD_SRC_MASK, 16'h0000, 17'h0_01FF);
		reg_op(1'b1, fault_pgood_pkg::CMD_PIN_STATUS, 16'hFFFF, 17'h1_0000);
		reg_op(1'b0, 8'hA0, 16'h0000, 17'h1_0000);
		// ---------------------------------------------------------------
		// Fault propagation with random enables, faults and peer pulls
		// ---------------------------------------------------------------
		repeat (32) begin
			r = xs();
			for (int k = 0; k < 4; k++)
				reg_op(1'b1, fault_pgood_pkg::CMD_ZONE0_PIN_A_PROP + 8'(k), {15'h0, r[k]}, 17'h0_0000);
			foff <= r[15:8] & r[23:16];
			peer <= r[27:24];
			de = r[3:0] & {{2{|(r[15:12] & r[23:20])}}, {2{|(r[11:8] & r[19:16])}}};
			@(negedge sys_clk);
			chk("zone0 drive", {15'h0, pins.oe[1:0]}, {15'h0, de[1:0]});
			chk("zone1 drive", {15'h0, pins.oe[3:2]}, {15'h0, de[3:2]});
			chk("fault data", {13'h0, pins.o}, 17'h0_0000);
		end
		// ---------------------------------------------------------------
		// Power-good mapping with random mask, status and watchdog
		// ---------------------------------------------------------------
		repeat (48) begin
			r = xs();
			s = xs();
			reg_op(1'b1, fault_pgood_pkg::CMD_PGOOD_SRC_MASK, {7'h00, r[8:0]}, 17'h0_0000);
			pg <= s[7:0] | s[15:8] | s[23:16];
			hr <= s[31:24];
			wdx <= r[20];
			used = r[7:0] & ~(s[31:24] & fault_pgood_pkg::ODD_CHAN_MASK);
			pg_exp = (&((s[7:0] | s[15:8] | s[23:16]) | ~used)) & (~r[8] | ~r[20]);
			@(negedge sys_clk);
			chk("power good", {16'h0, pgood}, {16'h0, pg_exp});
		end
		// ---------------------------------------------------------------
		// Clock enable freeze, status readback, reset in mid-run
		// ---------------------------------------------------------------
		for (int k = 0; k < 4; k++)
			reg_op(1'b1, fault_pgood_pkg::CMD_ZONE0_PIN_A_PROP + 8'(k), {15'h0, k == 0}, 17'h0_0000);
		reg_op(1'b1, fault_pgood_pkg::CMD_PGOOD_SRC_MASK, 16'h0001, 17'h0_0000);
		foff <= 8'h01;
		pg <= 8'h01;
		peer <= 4'h0;
		@(negedge sys_clk);
		clk_en <= 1'b0;
		foff <= 8'h00;
		pg <= 8'h00;
		req <= '{wr: 1'b1, rd: 1'b0, cmd: fault_pgood_pkg::CMD_ZONE0_PIN_A_PROP, wdata: 16'h0000};
		repeat (3) @(negedge sys_clk);
		chk("frozen drive", {13'h0, pins.oe}, 17'h0_0001);
		chk("frozen power good", {16'h0, pgood}, 17'h0_0001);
		clk_en <= 1'b1;
		req <= '0;
		@(negedge sys_clk);
		chk("thawed drive", {13'h0, pins.oe}, 17'h0_0000);
		chk("thawed power good", {16'h0, pgood}, 17'h0_0000);
		foff <= 8'h01;
		pg <= 8'h01;
		peer <= 4'h4;
		@(negedge sys_clk);
		reg_op(1'b0, fault_pgood_pkg::CMD_PIN_STATUS, 16'h0000, 17'h0_01A1);
		arst_n <= 1'b0;
		@(negedge sys_clk);
		arst_n <= 1'b1;
		@(negedge sys_clk);
		chk("reset power good", {16'h0, pgood}, 17'h0_0000);
		repeat (2) @(negedge sys_clk);
		chk("reset drive", {13'h0, pins.oe}, 17'h0_0000);
		chk("idle power good", {16'h0, pgood}, 17'h0_0001);
		reg_op(1'b0, fault_pgood_pkg::CMD_ZONE0_PIN_A_PROP, 16'h0000, 17'h0_0000);
		reg_op(1'b0, fault_pgood_pkg::CMD_PGOOD_SRC_MASK, 16'h0000, 17'h0_0000);
		for (int i = 0; i < 8 && exp_q.size() != 0; i++)
			@(negedge sys_clk);
		if (exp_q.size() != 0)
			chk("response count", 17'(exp_q.size()), 17'h0_0000);
		print_verdict();
	end
endmodule
